// file: rtl/terminal_pkg.sv
// Constants for the input terminal function decoder
package terminal_pkg;
  // Terminal layout: four plain terminals, then pulse_input_a and pulse_input_b
  localparam int NUM_TERM = 6;
  localparam int NUM_PLAIN = 4;
  localparam int IDX_PULSE_A = 4;
  localparam int IDX_PULSE_B = 5;
  localparam int CODE_W = 5;
  localparam int SYNC_STAGES = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_FUNC_LO = 8'h00;
  localparam logic [7:0] OFS_FUNC_HI = 8'h04;
  localparam logic [7:0] OFS_PULSE_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;

  // Field positions
  localparam int FUNC_LANE_W = 8;
  localparam int PCFG_A_MODE = 0;
  localparam int PCFG_B_MODE = 1;
  localparam int PCFG_A_ROLE = 2;
  localparam int PCFG_B_ROLE = 3;
  localparam int ST_TERM_LSB = 0;
  localparam int ST_FAULT = 8;
  localparam int ST_STEP_LSB = 12;
  localparam int ST_RAMP_LSB = 16;
  localparam int ST_FREEZE = 20;
  localparam int CMD_FWD = 0;
  localparam int CMD_REV = 1;
  localparam int CMD_3WIRE = 2;
  localparam int CMD_JOG_F = 3;
  localparam int CMD_JOG_R = 4;
  localparam int CMD_COAST = 5;
  localparam int CMD_PAUSE = 6;
  localparam int CMD_UP = 7;
  localparam int CMD_DOWN = 8;
  localparam int CMD_CLR = 9;
  localparam int CMD_AB = 10;
  localparam int CMD_CA = 11;
  localparam int CMD_CB = 12;
  localparam int CMD_SEQP = 13;

  // Reset values
  localparam logic [CODE_W-1:0] FUNC_RST = 5'h00;
  localparam logic [3:0] PCFG_RST = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Function codes
  localparam logic [CODE_W-1:0] FN_NONE = 5'h00;
  localparam logic [CODE_W-1:0] FN_FWD = 5'h01;
  localparam logic [CODE_W-1:0] FN_REV = 5'h02;
  localparam logic [CODE_W-1:0] FN_3WIRE = 5'h03;
  localparam logic [CODE_W-1:0] FN_JOG_F = 5'h04;
  localparam logic [CODE_W-1:0] FN_JOG_R = 5'h05;
  localparam logic [CODE_W-1:0] FN_COAST = 5'h06;
  localparam logic [CODE_W-1:0] FN_FRST = 5'h07;
  localparam logic [CODE_W-1:0] FN_PAUSE = 5'h08;
  localparam logic [CODE_W-1:0] FN_EXTF = 5'h09;
  localparam logic [CODE_W-1:0] FN_UP = 5'h0A;
  localparam logic [CODE_W-1:0] FN_DOWN = 5'h0B;
  localparam logic [CODE_W-1:0] FN_CLR = 5'h0C;
  localparam logic [CODE_W-1:0] FN_AB = 5'h0D;
  localparam logic [CODE_W-1:0] FN_CA = 5'h0E;
  localparam logic [CODE_W-1:0] FN_CB = 5'h0F;
  localparam logic [CODE_W-1:0] FN_STEP1 = 5'h10;
  localparam logic [CODE_W-1:0] FN_STEP2 = 5'h11;
  localparam logic [CODE_W-1:0] FN_STEP3 = 5'h12;
  localparam logic [CODE_W-1:0] FN_STEP4 = 5'h13;
  localparam logic [CODE_W-1:0] FN_FREEZE = 5'h14;
  localparam logic [CODE_W-1:0] FN_RAMP1 = 5'h15;
  localparam logic [CODE_W-1:0] FN_RAMP2 = 5'h16;
  localparam logic [CODE_W-1:0] FN_SEQ_RST = 5'h17;
  localparam logic [CODE_W-1:0] FN_SEQ_PAUSE = 5'h18;

  // Ramp time groups
  typedef enum logic [1:0] {
    RAMP_GROUP1,
    RAMP_GROUP2,
    RAMP_GROUP3,
    RAMP_GROUP4
  } ramp_group_t;
endpackage

// file: rtl/level_sync.sv
// Two-stage synchroniser for asynchronous terminal levels
module level_sync
  import terminal_pkg::*;
#(
  parameter int WIDTH = NUM_TERM
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // level_sync

// file: rtl/input_terminal_function_decoder.sv
// Multi-function input terminal decoder with AXI4-Lite configuration
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module input_terminal_function_decoder
  import terminal_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Terminals from external contacts
  input wire logic [NUM_PLAIN-1:0] terminal_in,
  input wire logic pulse_input_a,
  input wire logic pulse_input_b,
  // Pulse path towards measurement
  output logic pulse_a_train,
  output logic pulse_b_train,
  output logic pulse_a_is_encoder,
  output logic pulse_b_is_encoder,
  // Decoded commands
  output logic forward_run_cmd,
  output logic reverse_run_cmd,
  output logic three_wire_mode,
  output logic jog_forward_req,
  output logic jog_reverse_req,
  output logic coast_stop,
  output logic fault_reset_pulse,
  output logic run_pause,
  output logic ext_fault_alarm,
  output logic freq_up,
  output logic freq_down,
  output logic freq_offset_clear,
  output logic ref_swap_ab,
  output logic ref_swap_combo_a,
  output logic ref_swap_combo_b,
  output logic [3:0] speed_step,
  output ramp_group_t ramp_group,
  output logic seq_restart_pulse,
  output logic seq_pause
);

  logic [CODE_W-1:0] func_ff [NUM_TERM];
  logic [3:0] pcfg_ff;
  logic [NUM_TERM-1:0] term_sync;
  logic [NUM_TERM-1:0] digital_en;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic fault_ff;
  logic frst_prev_ff;
  logic seqr_prev_ff;
  logic [3:0] step_ff;
  logic [3:0] nxt_step;
  logic [13:0] cmd_ff;
  logic [13:0] nxt_cmd;
  logic fn_frst;
  logic fn_extf;
  logic fn_seqr;
  logic fn_freeze;
  logic clr_fault_sw;
  logic [31:0] rd_word;
  logic rd_hit;

  // Asserted when any digital terminal carrying the given code is closed
  function automatic logic code_active(
    input logic [CODE_W-1:0] code,
    input logic [CODE_W-1:0] fsel [NUM_TERM],
    input logic [NUM_TERM-1:0] lvl,
    input logic [NUM_TERM-1:0] en
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (en[i] && lvl[i] && fsel[i] == code && code != FN_NONE) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Register map decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == OFS_FUNC_LO || addr == OFS_FUNC_HI || addr == OFS_PULSE_CFG ||
      addr == OFS_STATUS || addr == OFS_CMD;
  endfunction

  // Contacts are asynchronous to mclk
  level_sync #(
    .WIDTH(NUM_TERM)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({pulse_input_b, pulse_input_a, terminal_in}),
    .sync_out(term_sync)
  );

  // Pulse-mode inputs leave function decoding entirely
  always_comb begin
    digital_en = '1;
    digital_en[IDX_PULSE_A] = ~pcfg_ff[PCFG_A_MODE];
    digital_en[IDX_PULSE_B] = ~pcfg_ff[PCFG_B_MODE];
  end

  // AXI write: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign do_write = aw_got_ff && w_got_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (do_write) begin
      w_got_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Function selection, one byte lane per terminal
  generate
    for (genvar t = 0; t < NUM_TERM; t++) begin : g_func
      localparam logic [7:0] T_OFS = (t < NUM_PLAIN) ? OFS_FUNC_LO : OFS_FUNC_HI;
      localparam int T_LANE = t % NUM_PLAIN;
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          func_ff[t] <= FUNC_RST;
        end else if (do_write && awaddr_ff == T_OFS && wstrb_ff[T_LANE]) begin
          func_ff[t] <= wdata_ff[T_LANE*FUNC_LANE_W +: CODE_W];
        end
      end
    end
  endgenerate

  // Pulse input mode and role
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pcfg_ff <= PCFG_RST;
    end else if (do_write && awaddr_ff == OFS_PULSE_CFG && wstrb_ff[0]) begin
      pcfg_ff <= wdata_ff[3:0];
    end
  end

  assign clr_fault_sw = do_write && awaddr_ff == OFS_STATUS && wstrb_ff[1] &&
    wdata_ff[ST_FAULT];

  // Read path: registered data, one read at a time
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = is_mapped(s_axi_araddr);
    case (s_axi_araddr)
      OFS_FUNC_LO: begin
        for (int i = 0; i < NUM_PLAIN; i++) begin
          rd_word[i*FUNC_LANE_W +: CODE_W] = func_ff[i];
        end
      end
      OFS_FUNC_HI: begin
        rd_word[0 +: CODE_W] = func_ff[IDX_PULSE_A];
        rd_word[FUNC_LANE_W +: CODE_W] = func_ff[IDX_PULSE_B];
      end
      OFS_PULSE_CFG: rd_word[3:0] = pcfg_ff;
      OFS_STATUS: begin
        rd_word[ST_TERM_LSB +: NUM_TERM] = term_sync;
        rd_word[ST_FAULT] = fault_ff;
        rd_word[ST_STEP_LSB +: 4] = step_ff;
        rd_word[ST_RAMP_LSB +: 2] = ramp_group;
        rd_word[ST_FREEZE] = fn_freeze;
      end
      OFS_CMD: rd_word[13:0] = cmd_ff;
      default: rd_word = 32'h00000000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Level commands decoded from the terminals
  assign fn_frst = code_active(FN_FRST, func_ff, term_sync, digital_en);
  assign fn_extf = code_active(FN_EXTF, func_ff, term_sync, digital_en);
  assign fn_seqr = code_active(FN_SEQ_RST, func_ff, term_sync, digital_en);
  assign fn_freeze = code_active(FN_FREEZE, func_ff, term_sync, digital_en);

  always_comb begin
    nxt_cmd = '0;
    nxt_cmd[CMD_FWD] = code_active(FN_FWD, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_REV] = code_active(FN_REV, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_3WIRE] = code_active(FN_3WIRE, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_JOG_F] = code_active(FN_JOG_F, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_JOG_R] = code_active(FN_JOG_R, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_COAST] = code_active(FN_COAST, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_PAUSE] = code_active(FN_PAUSE, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_UP] = code_active(FN_UP, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_DOWN] = code_active(FN_DOWN, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_CLR] = code_active(FN_CLR, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_AB] = code_active(FN_AB, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_CA] = code_active(FN_CA, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_CB] = code_active(FN_CB, func_ff, term_sync, digital_en);
    nxt_cmd[CMD_SEQP] = code_active(FN_SEQ_PAUSE, func_ff, term_sync, digital_en);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  assign forward_run_cmd = cmd_ff[CMD_FWD];
  assign reverse_run_cmd = cmd_ff[CMD_REV];
  assign three_wire_mode = cmd_ff[CMD_3WIRE];
  assign jog_forward_req = cmd_ff[CMD_JOG_F];
  assign jog_reverse_req = cmd_ff[CMD_JOG_R];
  assign coast_stop = cmd_ff[CMD_COAST];
  assign run_pause = cmd_ff[CMD_PAUSE];
  assign freq_up = cmd_ff[CMD_UP];
  assign freq_down = cmd_ff[CMD_DOWN];
  assign freq_offset_clear = cmd_ff[CMD_CLR];
  assign ref_swap_ab = cmd_ff[CMD_AB];
  assign ref_swap_combo_a = cmd_ff[CMD_CA];
  assign ref_swap_combo_b = cmd_ff[CMD_CB];
  assign seq_pause = cmd_ff[CMD_SEQP];

  // Edge pulses: a held contact must reset only once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frst_prev_ff <= 1'b0;
      seqr_prev_ff <= 1'b0;
      fault_reset_pulse <= 1'b0;
      seq_restart_pulse <= 1'b0;
    end else begin
      frst_prev_ff <= fn_frst;
      seqr_prev_ff <= fn_seqr;
      fault_reset_pulse <= fn_frst && !frst_prev_ff;
      seq_restart_pulse <= fn_seqr && !seqr_prev_ff;
    end
  end

  // External fault latch; a closed fault contact beats any clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_ff <= 1'b0;
    end else if (fn_extf) begin
      fault_ff <= 1'b1;
    end else if ((fn_frst && !frst_prev_ff) || clr_fault_sw) begin
      fault_ff <= 1'b0;
    end
  end

  assign ext_fault_alarm = fault_ff;

  // Speed step index, held while frozen
  always_comb begin
    nxt_step = step_ff;
    if (!fn_freeze) begin
      nxt_step[0] = code_active(FN_STEP1, func_ff, term_sync, digital_en);
      nxt_step[1] = code_active(FN_STEP2, func_ff, term_sync, digital_en);
      nxt_step[2] = code_active(FN_STEP3, func_ff, term_sync, digital_en);
      nxt_step[3] = code_active(FN_STEP4, func_ff, term_sync, digital_en);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      step_ff <= 4'h0;
    end else begin
      step_ff <= nxt_step;
    end
  end

  assign speed_step = step_ff;

  // Ramp group from the two selection terminals
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ramp_group <= RAMP_GROUP1;
    end else begin
      case ({code_active(FN_RAMP2, func_ff, term_sync, digital_en),
             code_active(FN_RAMP1, func_ff, term_sync, digital_en)})
        2'h0: ramp_group <= RAMP_GROUP1;
        2'h1: ramp_group <= RAMP_GROUP2;
        2'h2: ramp_group <= RAMP_GROUP3;
        2'h3: ramp_group <= RAMP_GROUP4;
        default: ramp_group <= RAMP_GROUP1;
      endcase
    end
  end

  // Pulse trains pass only in pulse mode; zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_a_train <= 1'b0;
      pulse_b_train <= 1'b0;
      pulse_a_is_encoder <= 1'b0;
      pulse_b_is_encoder <= 1'b0;
    end else begin
      pulse_a_train <= pcfg_ff[PCFG_A_MODE] && term_sync[IDX_PULSE_A];
      pulse_b_train <= pcfg_ff[PCFG_B_MODE] && term_sync[IDX_PULSE_B];
      pulse_a_is_encoder <= pcfg_ff[PCFG_A_ROLE];
      pulse_b_is_encoder <= pcfg_ff[PCFG_B_ROLE];
    end
  end

endmodule // input_terminal_function_decoder

// file: verification/terminal_decoder_assertions.sv
// Checker for bus handshakes, command pulses and terminal latency
module terminal_decoder_checker
  import terminal_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pulse_input_a,
  input wire logic pulse_a_train,
  input wire logic fault_reset_pulse,
  input wire logic seq_restart_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Write halves taken at one edge
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence

  write_answer_a: assert property ((aw_taken and w_taken) |-> ##2 s_axi_bvalid)
    else $error("write response not one cycle after both halves");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  resp_code_a: assert property (s_axi_bvalid |->
    (s_axi_bresp == RESP_OKAY) || (s_axi_bresp == RESP_SLVERR)) else $error("bad bresp");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data unstable");
  read_gate_a: assert property (s_axi_arready != s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  fault_pulse_a: assert property (fault_reset_pulse |=> !fault_reset_pulse)
    else $error("fault reset longer than one cycle");
  restart_pulse_a: assert property (seq_restart_pulse |=> !seq_restart_pulse)
    else $error("sequencer restart longer than one cycle");
  sync_delay_a: assert property ($rose(pulse_a_train) |-> $past(pulse_input_a, 3))
    else $error("pulse train rose without synced input");
endmodule // terminal_decoder_checker

bind input_terminal_function_decoder terminal_decoder_checker i_chk (
  .mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_input_a,
  .pulse_a_train, .fault_reset_pulse, .seq_restart_pulse
);

// file: verification/contact_bank.sv
// Model of the external switch contacts on the six terminals
module contact_bank (
  input wire logic [5:0] closed,
  output logic [3:0] terminal_in,
  output logic pulse_input_a,
  output logic pulse_input_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle a few ns after the command, unrelated to the clock edge
  initial {pulse_input_b, pulse_input_a, terminal_in} = 6'h00;
  always @(closed) {pulse_input_b, pulse_input_a, terminal_in} <= #7 closed;
endmodule // contact_bank

// file: verification/tb_top.sv
// Self-checking bench for the input terminal function decoder
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import terminal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, terminal_in, speed_step;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pulse_input_a, pulse_input_b, pulse_a_train, pulse_b_train;
  logic pulse_a_is_encoder, pulse_b_is_encoder, forward_run_cmd, reverse_run_cmd;
  logic three_wire_mode, jog_forward_req, jog_reverse_req, coast_stop;
  logic fault_reset_pulse, run_pause, ext_fault_alarm, freq_up, freq_down;
  logic freq_offset_clear, ref_swap_ab, ref_swap_combo_a, ref_swap_combo_b;
  logic seq_restart_pulse, seq_pause;
  ramp_group_t ramp_group;
  logic [5:0] closed = 6'h00;
  int miscompares = 0, n_checks = 0, n_fr = 0, n_sr = 0;
  localparam logic [4:0] LC [16] = '{FN_FWD, FN_REV, FN_3WIRE, FN_JOG_F, FN_JOG_R,
    FN_COAST, FN_PAUSE, FN_UP, FN_DOWN, FN_CLR, FN_AB, FN_CA, FN_CB, FN_SEQ_PAUSE,
    FN_NONE, 5'h19};

  input_terminal_function_decoder i_dut (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .terminal_in, .pulse_input_a, .pulse_input_b, .pulse_a_train, .pulse_b_train,
    .pulse_a_is_encoder, .pulse_b_is_encoder, .forward_run_cmd, .reverse_run_cmd,
    .three_wire_mode, .jog_forward_req, .jog_reverse_req, .coast_stop,
    .fault_reset_pulse, .run_pause, .ext_fault_alarm, .freq_up, .freq_down,
    .freq_offset_clear, .ref_swap_ab, .ref_swap_combo_a, .ref_swap_combo_b,
    .speed_step, .ramp_group, .seq_restart_pulse, .seq_pause);
  contact_bank i_contacts (.closed, .terminal_in, .pulse_input_a, .pulse_input_b);

  // 25 MHz clock
  always #20 mclk = ~mclk;
  // Pulse counters, so one-cycle strobes are never missed by a later look
  always @(posedge mclk) begin
    n_fr += fault_reset_pulse;
    n_sr += seq_restart_pulse;
  end

  function automatic logic [13:0] cmds();
    return {seq_pause, ref_swap_combo_b, ref_swap_combo_a, ref_swap_ab,
      freq_offset_clear, freq_down, freq_up, run_pause, coast_stop, jog_reverse_req,
      jog_forward_req, three_wire_mode, reverse_run_cmd, forward_run_cmd};
  endfunction

  // Ready is sampled at the falling edge, so no race with the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ha, hw, hb;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge mclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ha, hr;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge mclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Set contacts, then wait past the sync and decode latency
  task automatic sw(input logic [5:0] v);
    @(posedge mclk);
    closed <= v;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    `CHK("cmd_rst", 14'h0000, cmds())
    `CHK("ramp_rst", RAMP_GROUP1, ramp_group)
    rd(OFS_FUNC_LO, d, r);
    `CHK("func_lo_rst", 32'h00000000, d)
    rd(OFS_PULSE_CFG, d, r);
    `CHK("pcfg_rst", 32'h00000000, d)
    wr(8'h40, 32'h13131313, r);
    `CHK("wr_unmapped", RESP_SLVERR, r)
    rd(8'h40, d, r);
    `CHK("rd_unmapped", RESP_SLVERR, r)
    `CHK("rd_unmapped_data", 32'h00000000, d)
    rd(OFS_FUNC_LO, d, r);
    `CHK("no_side_effect", 32'h00000000, d)
  endtask

  // Every level code on terminal 2, plus code 0 and an undefined code
  task automatic t_levels;
    logic [31:0] d;
    logic [1:0] r;
    logic [13:0] e;
    for (int k = 0; k < 16; k++) begin
      wr(OFS_FUNC_LO, {11'h000, LC[k], 16'h0000}, r);
      e = (k < 14) ? 14'h0001 << k : 14'h0000;
      sw(6'h04);
      `CHK("cmd", e, cmds())
      rd(OFS_CMD, d, r);
      `CHK("cmd_reg", e, d[13:0])
      `CHK("no_fault", 1'b0, ext_fault_alarm)
      sw(6'h00);
      `CHK("cmd_off", 14'h0000, cmds())
    end
  endtask

  task automatic t_step;
    logic [31:0] d;
    logic [1:0] r;
    // Distinct codes per terminal, duplicates are a configuration error
    wr(OFS_FUNC_LO, {3'h0, FN_STEP4, 3'h0, FN_STEP3, 3'h0, FN_STEP2, 3'h0, FN_STEP1}, r);
    rd(OFS_FUNC_LO, d, r);
    `CHK("func_lo", 32'h13121110, d & 32'h1F1F1F1F)
    for (int v = 0; v < 16; v++) begin
      sw({2'b00, 4'(v)});
      `CHK("step", 4'(v), speed_step)
    end
    wr(OFS_FUNC_HI, {27'h0000000, FN_FREEZE}, r);
    // Steps settle before freeze closes; a joint change would keep the old step
    sw(6'h0A);
    sw(6'h1A);
    `CHK("step_frozen_set", 4'hA, speed_step)
    sw(6'h15);
    `CHK("step_frozen", 4'hA, speed_step)
    sw(6'h05);
    `CHK("step_thawed", 4'h5, speed_step)
    wr(OFS_FUNC_HI, 32'h00000000, r);
  endtask

  task automatic t_ramp;
    logic [1:0] r;
    wr(OFS_FUNC_LO, {19'h00000, FN_RAMP2, 3'h0, FN_RAMP1}, r);
    for (int k = 0; k < 4; k++) begin
      sw({4'h0, 2'(k)});
      `CHK("ramp", ramp_group_t'(2'(k)), ramp_group)
    end
  endtask

  task automatic t_fault;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_FUNC_LO, {11'h000, FN_SEQ_RST, 3'h0, FN_FRST, 3'h0, FN_EXTF}, r);
    sw(6'h01);
    `CHK("ext_fault", 1'b1, ext_fault_alarm)
    sw(6'h00);
    `CHK("fault_latched", 1'b1, ext_fault_alarm)
    rd(OFS_STATUS, d, r);
    `CHK("status_fault", 1'b1, d[ST_FAULT])
    // Software clear of the latch, then latch again for the contact reset
    wr(OFS_STATUS, 32'h00000100, r);
    `CHK("sw_fault_clear", 1'b0, ext_fault_alarm)
    sw(6'h01);
    sw(6'h00);
    `CHK("fault_relatched", 1'b1, ext_fault_alarm)
    n_fr = 0;
    n_sr = 0;
    sw(6'h02);
    `CHK("reset_pulses", 1, n_fr)
    `CHK("fault_cleared", 1'b0, ext_fault_alarm)
    sw(6'h04);
    `CHK("restart_pulses", 1, n_sr)
    sw(6'h00);
    `CHK("no_release_pulse", 1, n_fr + n_sr - 1)
  endtask

  task automatic t_pulse;
    logic [1:0] r;
    wr(OFS_FUNC_HI, {19'h00000, FN_REV, 3'h0, FN_FWD}, r);
    wr(OFS_PULSE_CFG, 32'h00000005, r);
    sw(6'h30);
    `CHK("train_a", 1'b1, pulse_a_train)
    `CHK("enc_a", 1'b1, pulse_a_is_encoder)
    `CHK("enc_b", 1'b0, pulse_b_is_encoder)
    `CHK("train_b", 1'b0, pulse_b_train)
    `CHK("pulse_no_decode", 1'b0, forward_run_cmd)
    `CHK("digital_b", 1'b1, reverse_run_cmd)
    sw(6'h00);
    `CHK("train_a_off", 1'b0, pulse_a_train)
    wr(OFS_PULSE_CFG, 32'h00000000, r);
    sw(6'h10);
    `CHK("digital_a", 1'b1, forward_run_cmd)
  endtask

  task summarize;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #(40 * 30000);
    miscompares++;
    summarize;
  end

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_regs;
    t_levels;
    t_step;
    t_ramp;
    t_fault;
    t_pulse;
    summarize;
  end
endmodule // tb_top
